// File: pp_xfer_pkg.sv
// Purpose: shared constants and types for the parallel-transfer opcode decoder
// Assumes: 64-bit opcode, APB register access with 32-bit data
// Notes:   transfer field positions are fixed here; the decoder takes them by name, the bench uses literal bit numbers
package pp_xfer_pkg;

  localparam int unsigned OPC_W      = 64;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned APB_AW     = 12;
  localparam int unsigned REG_CODE_W = 7;

  // data-unit format selection bits
  localparam int unsigned DU_TOP_BIT  = 63;
  localparam int unsigned DU_LSB      = 38;
  localparam int unsigned DU_SEL1_BIT = 44;
  localparam int unsigned DU_SEL0_BIT = 43;
  localparam int unsigned MISC_HI     = 62;
  localparam int unsigned MISC_LO     = 58;
  localparam logic [4:0]  MISC_PAT    = 5'h01;

  // parallel-transfer field positions
  localparam int unsigned PT_SEL_LSB = 35;
  localparam int unsigned PT_HI      = 38;
  localparam int unsigned L_BIT      = 34;
  localparam int unsigned AUA_BIT    = 33;
  localparam int unsigned G_BIT      = 32;
  localparam int unsigned SIGN_BIT   = 31;
  localparam int unsigned SIZE_LSB   = 29;
  localparam int unsigned ITEM_LSB   = 27;
  localparam int unsigned REP_BIT    = 26;
  localparam int unsigned DST_LSB    = 19;
  localparam int unsigned SRC_LSB    = 12;
  localparam int unsigned AREG_LSB   = 8;

  // parallel-transfer formats, in listed order
  localparam logic [3:0] PT_DOUBLE  = 4'h0;
  localparam logic [3:0] PT_MOVE    = 4'h1;
  localparam logic [3:0] PT_FMOVE   = 4'h2;
  localparam logic [3:0] PT_LOCAL   = 4'h3;
  localparam logic [3:0] PT_GLOBAL  = 4'h4;
  localparam logic [3:0] PT_NONDU   = 4'h5;
  localparam logic [3:0] PT_CMOVE   = 4'h6;
  localparam logic [3:0] PT_CFMOVE  = 4'h7;
  localparam logic [3:0] PT_CGLOBAL = 4'h8;
  localparam logic [3:0] PT_CNONDU  = 4'h9;
  localparam logic [3:0] PT_COUNT   = 4'hA;
  localparam logic [3:0] PT_NONE    = 4'hF;

  // register byte offsets
  localparam logic [APB_AW-1:0] CTRL_OFS   = 12'h000;
  localparam logic [APB_AW-1:0] OPC_LO_OFS = 12'h004;
  localparam logic [APB_AW-1:0] OPC_HI_OFS = 12'h008;
  localparam logic [APB_AW-1:0] SRC_OFS    = 12'h00C;
  localparam logic [APB_AW-1:0] STATUS_OFS = 12'h010;
  localparam logic [APB_AW-1:0] RESULT_OFS = 12'h014;
  localparam logic [APB_AW-1:0] COUNT_OFS  = 12'h018;

  localparam logic             CTRL_EN_RST = 1'h1;
  localparam logic [DATA_W-1:0] WORD_RST   = 32'h0000_0000;
  localparam logic [15:0]       CNT_RST    = 16'h0000;

  typedef enum logic [2:0] {
    DU_SIX   = 3'h0,
    DU_IMM5  = 3'h1,
    DU_IMM32 = 3'h2,
    DU_REG   = 3'h3,
    DU_MISC  = 3'h6,
    DU_RSVD  = 3'h7
  } du_fmt_e;

  typedef enum logic [2:0] {
    OP_NONE      = 3'h0,
    OP_LOAD      = 3'h1,
    OP_STORE     = 3'h2,
    OP_ADDR      = 3'h3,
    OP_MOVE      = 3'h4,
    OP_EXTRACT   = 3'h5,
    OP_REPLICATE = 3'h6
  } op_e;

  typedef enum logic [1:0] {
    SZ_WORD = 2'h0,
    SZ_BYTE = 2'h1,
    SZ_HALF = 2'h2,
    SZ_RSVD = 2'h3
  } size_e;

  typedef struct packed {
    logic                  valid;
    logic                  illegal;
    du_fmt_e               du_fmt;
    logic [3:0]            pt_fmt;
    op_e                   op;
    size_e                 size;
    logic                  sign;
    logic [1:0]            item;
    logic                  glob;
    logic                  mem_rd;
    logic                  mem_wr;
    logic                  reg_we;
    logic [REG_CODE_W-1:0] dst;
    logic [REG_CODE_W-1:0] src;
    logic [3:0]            areg;
  } ctrl_s;

endpackage

// File: pp_field_unit.sv
// Purpose: byte/halfword extract and replicate for register field moves
// Assumes: size and item already checked by the decoder
// Notes:   purely combinational; the caller registers the result
module pp_field_unit
  import pp_xfer_pkg::*;
(
  input  wire logic [DATA_W-1:0] src_word,
  input  wire size_e             size,
  input  wire logic              sign,
  input  wire logic [1:0]        item,
  input  wire logic              replicate,
  output logic      [DATA_W-1:0] result
);

  logic [DATA_W-1:0] shifted;
  logic [4:0]        shamt;

  always_comb
  begin
    shamt   = (size == SZ_HALF) ? {item[0], 4'h0} : {item, 3'h0}; // RQ9
    shifted = src_word >> shamt;
    result  = src_word;
    if (replicate)
    begin
      if (size == SZ_BYTE)
        result = {4{src_word[7:0]}}; // RQ6
      else if (size == SZ_HALF)
        result = {2{src_word[15:0]}}; // RQ6
    end
    else
    begin
      // upper fill comes from the field itself, never from bits above it
      if (size == SZ_BYTE)
        result = {{24{sign & shifted[7]}}, shifted[7:0]}; // RQ5 RQ8
      else if (size == SZ_HALF)
        result = {{16{sign & shifted[15]}}, shifted[15:0]}; // RQ5 RQ8
    end
  end

endmodule

// File: pp_transfer_opcode_decoder.sv
// Purpose: decode the data-unit and parallel-transfer parts of a 64-bit opcode
// Assumes: fetch path and source operand on pclk; APB slave for software access
// Notes:   one pipeline stage from opcode to control; fetch path wins over APB issue
//
// How it works
// RQ1: a load reads memory at the computed address into the named register
// RQ2: a store writes the named register to memory at the computed address
// RQ3: address arithmetic writes the effective address to a register, no memory access
// RQ4: a move copies one register to another, optionally through the global unit
// RQ5: field extract right-aligns the chosen byte or halfword, zero or sign filled
// RQ6: field replicate copies the low byte or halfword across all 32 bits
// RQ7: size picks byte, halfword or word; word is the default encoding
// RQ8: sign selector picks zero or sign extension for narrow fields
// RQ9: item picks byte 0 to 3, or halfword 0 or 1
// RQ10: each instruction decodes from one 64-bit opcode with both portions
// RQ11: five data-unit formats live in bits 38 to 63
// RQ12: one of ten transfer formats in bits 0 to 38, none under 32-bit immediate
// RQ13: reserved leading-bit patterns are flagged illegal and never executed
module pp_transfer_opcode_decoder
  import pp_xfer_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              instr_valid,
  input  wire logic [OPC_W-1:0]  instr_word,
  input  wire logic [DATA_W-1:0] src_data,
  output ctrl_s                  ctrl,
  output logic      [DATA_W-1:0] move_data
);

  logic              ctrl_en_q;
  logic [DATA_W-1:0] opc_lo_q;
  logic [DATA_W-1:0] opc_hi_q;
  logic [DATA_W-1:0] src_q;
  logic              issue_q;
  logic [15:0]       dec_cnt_q;
  logic [15:0]       ill_cnt_q;
  logic [DATA_W-1:0] prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  ctrl_s             ctrl_q;
  logic [DATA_W-1:0] move_q;

  logic              apb_acc;
  logic              apb_done;
  logic              fire_hw;
  logic              fire_sw;
  logic              fire;
  logic [OPC_W-1:0]  opc;
  logic [DATA_W-1:0] opr;
  ctrl_s             dec;
  logic [DATA_W-1:0] field_res;
  logic              mapped;
  logic [DATA_W-1:0] rd_word;

  assign apb_acc  = psel & penable;
  assign apb_done = apb_acc & pready_q;
  assign fire_hw  = instr_valid & ctrl_en_q;
  assign fire_sw  = issue_q & ~fire_hw;
  assign fire     = fire_hw | fire_sw;
  assign opc      = fire_hw ? instr_word : {opc_hi_q, opc_lo_q}; // RQ10
  assign opr      = fire_hw ? src_data : src_q;

  // opcode classification
  always_comb
  begin
    dec        = '0;
    dec.valid  = fire;
    dec.sign   = opc[SIGN_BIT];
    dec.item   = opc[ITEM_LSB +: 2];
    dec.size   = size_e'(opc[SIZE_LSB +: 2]); // RQ7
    dec.dst    = opc[DST_LSB +: REG_CODE_W];
    dec.src    = opc[SRC_LSB +: REG_CODE_W];
    dec.areg   = opc[AREG_LSB +: 4];
    // leading bits first: misc shares its class field with the base set
    if (!opc[DU_TOP_BIT])
      dec.du_fmt = (opc[62:61] == 2'h3) ? DU_SIX : DU_RSVD; // RQ11 RQ13
    else if (opc[MISC_HI:MISC_LO] == MISC_PAT)
      dec.du_fmt = DU_MISC; // RQ11
    else if (!opc[DU_SEL1_BIT])
      dec.du_fmt = DU_IMM5; // RQ11
    else if (opc[DU_SEL0_BIT])
      dec.du_fmt = DU_IMM32; // RQ11
    else
      dec.du_fmt = DU_REG; // RQ11
    // the 32-bit immediate occupies the transfer field
    dec.pt_fmt = (dec.du_fmt == DU_IMM32) ? PT_NONE : opc[PT_HI:PT_SEL_LSB]; // RQ12
    unique case (dec.pt_fmt)
      PT_DOUBLE, PT_LOCAL, PT_GLOBAL, PT_CGLOBAL:
      begin
        if (opc[L_BIT])
          dec.op = OP_LOAD; // RQ1
        else if (opc[AUA_BIT])
          dec.op = OP_ADDR; // RQ3
        else
          dec.op = OP_STORE; // RQ2
        dec.glob = (dec.pt_fmt == PT_GLOBAL) || (dec.pt_fmt == PT_CGLOBAL);
      end
      PT_MOVE, PT_CMOVE:
      begin
        dec.op   = OP_MOVE; // RQ4
        dec.glob = opc[G_BIT]; // RQ4
        dec.size = SZ_WORD;
        dec.sign = 1'b0;
      end
      PT_FMOVE, PT_CFMOVE:
      begin
        dec.op = opc[REP_BIT] ? OP_REPLICATE : OP_EXTRACT; // RQ5 RQ6
        if (dec.op == OP_REPLICATE)
          dec.sign = 1'b0;
      end
      default:
        dec.op = OP_NONE;
    endcase
    if (dec.op != OP_EXTRACT)
      dec.item = 2'h0;
    // illegal patterns: reserved data-unit codes, unused transfer codes, bad size or item
    dec.illegal = (dec.du_fmt == DU_RSVD)
                | ((dec.du_fmt != DU_IMM32) && (opc[PT_HI:PT_SEL_LSB] >= PT_COUNT))
                | ((dec.op != OP_NONE) && (dec.size == SZ_RSVD))
                | ((dec.op == OP_EXTRACT) && (dec.size == SZ_WORD))
                | ((dec.op == OP_EXTRACT) && (dec.size == SZ_HALF) && dec.item[1]); // RQ9 RQ13
    if (dec.illegal)
      dec.op = OP_NONE; // RQ13
    dec.mem_rd = (dec.op == OP_LOAD); // RQ1
    dec.mem_wr = (dec.op == OP_STORE); // RQ2
    dec.reg_we = (dec.op == OP_LOAD) || (dec.op == OP_ADDR) || (dec.op == OP_MOVE)
               || (dec.op == OP_EXTRACT) || (dec.op == OP_REPLICATE); // RQ3
  end

  pp_field_unit u_field
  (
    .src_word  (opr),
    .size      (dec.size),
    .sign      (dec.sign),
    .item      (dec.item),
    .replicate (dec.op == OP_REPLICATE),
    .result    (field_res)
  );

  // decoded controls and move data, one cycle after the opcode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= '0;
      move_q <= WORD_RST;
    end
    else if (fire)
    begin
      ctrl_q <= dec;
      if ((dec.op == OP_EXTRACT) || (dec.op == OP_REPLICATE))
        move_q <= field_res; // RQ5 RQ6
      else if (dec.op == OP_MOVE)
        move_q <= opr; // RQ4
    end
    else
      ctrl_q.valid <= 1'b0;
  end

  // software issue request; a new request wins over its own completion
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      issue_q <= 1'b0;
    else if (apb_done && pwrite && (paddr == OPC_HI_OFS) && ctrl_en_q)
      issue_q <= 1'b1;
    else if (fire_sw)
      issue_q <= 1'b0;
  end

  // counters wrap; software reads the difference between samples
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dec_cnt_q <= CNT_RST;
      ill_cnt_q <= CNT_RST;
    end
    else if (fire)
    begin
      dec_cnt_q <= dec_cnt_q + 16'h0001;
      if (dec.illegal)
        ill_cnt_q <= ill_cnt_q + 16'h0001;
    end
  end

  // writable registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_en_q <= CTRL_EN_RST;
      opc_lo_q  <= WORD_RST;
      opc_hi_q  <= WORD_RST;
      src_q     <= WORD_RST;
    end
    else if (apb_done && pwrite)
    begin
      unique case (paddr)
        CTRL_OFS:   ctrl_en_q <= pwdata[0];
        OPC_LO_OFS: opc_lo_q  <= pwdata;
        OPC_HI_OFS: opc_hi_q  <= pwdata;
        SRC_OFS:    src_q     <= pwdata;
        default:    ;
      endcase
    end
  end

  always_comb
  begin
    mapped  = 1'b1;
    rd_word = WORD_RST;
    unique case (paddr)
      CTRL_OFS:   rd_word = {31'h0000_0000, ctrl_en_q};
      OPC_LO_OFS: rd_word = opc_lo_q;
      OPC_HI_OFS: rd_word = opc_hi_q;
      SRC_OFS:    rd_word = src_q;
      STATUS_OFS: rd_word = {14'h0000, ctrl_q.glob, ctrl_q.sign, ctrl_q.item, ctrl_q.size,
                             ctrl_q.op, ctrl_q.pt_fmt, ctrl_q.du_fmt, ctrl_q.illegal, issue_q};
      RESULT_OFS: rd_word = move_q;
      COUNT_OFS:  rd_word = {ill_cnt_q, dec_cnt_q};
      default:    mapped  = 1'b0;
    endcase
  end

  // one wait state: answer prepared in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= WORD_RST;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= apb_acc & ~pready_q;
      pslverr_q <= apb_acc & ~pready_q & ~mapped;
      if (apb_acc && !pready_q && !pwrite)
        prdata_q <= rd_word;
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign ctrl      = ctrl_q;
  assign move_data = move_q;

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_load_path: assert property ( // RQ1
    ctrl_q.valid && ctrl_q.op == OP_LOAD |-> ctrl_q.mem_rd && ctrl_q.reg_we && !ctrl_q.mem_wr)
    else $error("load without memory read and register write");
  chk_store_path: assert property ( // RQ2
    fire && dec.op == OP_STORE |=> ctrl_q.mem_wr && !ctrl_q.reg_we && !ctrl_q.mem_rd)
    else $error("store controls wrong");
  chk_addr_nomem: assert property ( // RQ3
    ctrl_q.valid && ctrl_q.op == OP_ADDR |-> !ctrl_q.mem_rd && !ctrl_q.mem_wr && ctrl_q.reg_we)
    else $error("address arithmetic touched memory");
  chk_move_copy: assert property (fire && dec.op == OP_MOVE |=> move_q == $past(opr)) // RQ4
    else $error("move data differs from source");
  chk_extract_fill: assert property ( // RQ5 RQ8
    ctrl_q.valid && ctrl_q.op == OP_EXTRACT && ctrl_q.size == SZ_BYTE && !ctrl_q.sign
    |-> move_q[31:8] == 24'h000000)
    else $error("unsigned byte extract not zero filled");
  chk_sign_fill: assert property ( // RQ8
    ctrl_q.valid && ctrl_q.op == OP_EXTRACT && ctrl_q.size == SZ_HALF && ctrl_q.sign
    |-> move_q[31:16] == {16{move_q[15]}})
    else $error("signed halfword extract not sign filled");
  chk_replicate_byte: assert property ( // RQ6
    ctrl_q.valid && ctrl_q.op == OP_REPLICATE && ctrl_q.size == SZ_BYTE
    |-> move_q == {4{$past(opr[7:0])}})
    else $error("byte replicate wrong");
  chk_move_word: assert property (ctrl_q.valid && ctrl_q.op == OP_MOVE |-> ctrl_q.size == SZ_WORD) // RQ7
    else $error("plain move not word sized");
  chk_item_range: assert property ( // RQ9
    ctrl_q.valid && ctrl_q.op == OP_EXTRACT && ctrl_q.size == SZ_HALF
    |-> ctrl_q.item < 2'h2)
    else $error("halfword item out of range");
  chk_decode_lat: assert property (fire |=> ctrl_q.valid ##1 (ctrl_q.valid == $past(fire))) // RQ10
    else $error("decode not one cycle after opcode");
  // a legal local transfer keeps a six-operand opcode legal
  chk_six_operand: assert property ( // RQ11
    fire && opc[63:61] == 3'h3 && opc[PT_HI:PT_SEL_LSB] == PT_LOCAL && opc[SIZE_LSB +: 2] != 2'h3
    |=> ctrl_q.du_fmt == DU_SIX && !ctrl_q.illegal)
    else $error("six-operand format missed");
  chk_imm32_nopt: assert property ( // RQ12
    fire && opc[63] && opc[44:43] == 2'h3 && opc[62:58] != MISC_PAT
    |=> ctrl_q.pt_fmt == PT_NONE && ctrl_q.op == OP_NONE)
    else $error("transfer decoded under 32-bit immediate");
  chk_reserved: assert property ( // RQ13
    fire && opc[63:62] == 2'h0 |=> ctrl_q.illegal && !ctrl_q.reg_we && !ctrl_q.mem_wr)
    else $error("reserved pattern not flagged");
  chk_apb_wait: assert property ($rose(apb_acc) |-> !pready ##1 pready) // RQ10
    else $error("apb answer not after one wait state");

  // field and plain moves; replicate and item picks held against the operand of the decode cycle
  chk_replicate_half: assert property ( // RQ6
    ctrl_q.valid && ctrl_q.op == OP_REPLICATE && ctrl_q.size == SZ_HALF
    |-> move_q == {2{$past(opr[15:0])}})
    else $error("halfword replicate wrong");
  chk_unsigned_half: assert property ( // RQ5 RQ8
    ctrl_q.valid && ctrl_q.op == OP_EXTRACT && ctrl_q.size == SZ_HALF && !ctrl_q.sign
    |-> move_q[31:16] == 16'h0000)
    else $error("unsigned halfword extract not zero filled");
  chk_byte_sign: assert property ( // RQ8
    ctrl_q.valid && ctrl_q.op == OP_EXTRACT && ctrl_q.size == SZ_BYTE && ctrl_q.sign
    |-> move_q[31:8] == {24{move_q[7]}})
    else $error("signed byte extract not sign filled");
  chk_byte_item: assert property ( // RQ9
    fire && dec.op == OP_EXTRACT && dec.size == SZ_BYTE
    |=> move_q[7:0] == $past(opr[{dec.item, 3'h0} +: 8]))
    else $error("byte extract took the wrong item");
  chk_half_item: assert property ( // RQ9
    fire && dec.op == OP_EXTRACT && dec.size == SZ_HALF
    |=> move_q[15:0] == $past(opr[{dec.item[0], 4'h0} +: 16]))
    else $error("halfword extract took the wrong item");
  chk_move_hold: assert property ( // RQ4
    ctrl_q.valid && !(ctrl_q.op inside {OP_MOVE, OP_EXTRACT, OP_REPLICATE}) |-> $stable(move_q))
    else $error("move data changed by a non-move");
  chk_glob_move: assert property ( // RQ4
    fire && dec.op == OP_MOVE |=> ctrl_q.glob == $past(opc[G_BIT]))
    else $error("move global selector lost");

  // decode fields and format classes
  chk_load_dst: assert property ( // RQ1
    fire && dec.op == OP_LOAD |=> ctrl_q.dst == $past(opc[DST_LSB +: REG_CODE_W]))
    else $error("load destination lost");
  chk_load_size: assert property ( // RQ7
    fire && dec.op == OP_LOAD |=> ctrl_q.size == $past(opc[SIZE_LSB +: 2]))
    else $error("load size lost");
  chk_idle_novalid: assert property ( // RQ10
    !fire |=> !ctrl_q.valid)
    else $error("decode strobe without an opcode");
  chk_six_xfer: assert property ( // RQ12
    fire && opc[63:61] == 3'h3 |=> ctrl_q.pt_fmt == $past(opc[PT_HI:PT_SEL_LSB]))
    else $error("transfer format lost under six-operand");
  chk_misc_fmt: assert property ( // RQ11
    fire && opc[DU_TOP_BIT] && opc[MISC_HI:MISC_LO] == MISC_PAT |=> ctrl_q.du_fmt == DU_MISC)
    else $error("miscellaneous format missed");
  chk_high_xfer: assert property ( // RQ13
    fire && opc[DU_TOP_BIT] && opc[DU_SEL1_BIT:DU_SEL0_BIT] != 2'h3
    && opc[PT_HI:PT_SEL_LSB] >= PT_COUNT |=> ctrl_q.illegal)
    else $error("unused transfer code not flagged");
  chk_illegal_quiet: assert property ( // RQ13
    ctrl_q.valid && ctrl_q.illegal
    |-> ctrl_q.op == OP_NONE && !ctrl_q.mem_rd && !ctrl_q.mem_wr && !ctrl_q.reg_we)
    else $error("illegal opcode still drives strobes");

endmodule

// File: pp_fetch_model.sv
// Purpose: fetch-side model that hands opcodes and operands to the decoder
// Assumes: bench raises req_valid for one cycle per opcode
// Notes:   idle opcode bus toggles every cycle so a stale word never looks fresh
module pp_fetch_model
  import pp_xfer_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              req_valid,
  input  wire logic [OPC_W-1:0]  req_word,
  input  wire logic [DATA_W-1:0] req_src,
  output logic                   instr_valid,
  output logic      [OPC_W-1:0]  instr_word,
  output logic      [DATA_W-1:0] src_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [OPC_W-1:0] junk_q = 64'h5A5A_C3C3_0FF0_A55A;
  always @(posedge pclk) junk_q <= ~junk_q;
  assign instr_valid = req_valid;
  assign instr_word  = req_valid ? req_word : junk_q;
  assign src_data    = req_valid ? req_src : junk_q[63:32];
endmodule

// File: pp_transfer_opcode_decoder_test.sv
// Purpose: self-checking bench for the transfer opcode decoder
// Assumes: fetch model on the opcode path, APB driven by tasks here
// Notes:   random opcodes stay in known formats; corners cover reserved codes
module pp_transfer_opcode_decoder_test;
  import pp_xfer_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, instr_valid, req_valid = 0;
  logic [APB_AW-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, src_data, move_data, req_src = '0, md_exp = '0, rd;
  logic [OPC_W-1:0]  instr_word, req_word = '0, w;
  ctrl_s             ctrl, e;
  logic              err;
  int                fails = 0, n_tests = 0, seed = 97, dec_cnt = 0, ill_cnt = 0, n;
  logic [63:0]       q [$];

  always #10 pclk = ~pclk;

  pp_fetch_model u_fetch (.pclk(pclk), .req_valid(req_valid), .req_word(req_word), .req_src(req_src),
    .instr_valid(instr_valid), .instr_word(instr_word), .src_data(src_data));
  pp_transfer_opcode_decoder u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_valid(instr_valid), .instr_word(instr_word), .src_data(src_data), .ctrl(ctrl), .move_data(move_data));

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // only the watchdog ends a wait that never completes
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  function automatic ctrl_s expect_of(input logic [63:0] x, input logic [31:0] s);
    ctrl_s c;
    logic [31:0] f;
    c = '0;
    c.valid = 1'b1;
    if (!x[63]) c.du_fmt = (x[62:61] == 2'b11) ? DU_SIX : DU_RSVD;
    else if (x[62:58] == MISC_PAT) c.du_fmt = DU_MISC;
    else if (!x[44]) c.du_fmt = DU_IMM5;
    else c.du_fmt = x[43] ? DU_IMM32 : DU_REG;
    c.pt_fmt = (c.du_fmt == DU_IMM32) ? PT_NONE : x[38:35];
    if (c.du_fmt == DU_IMM32) return c;
    c.sign = x[31];
    c.size = size_e'(x[30:29]);
    c.item = x[28:27];
    {c.dst, c.src, c.areg} = x[25:8];
    case (c.pt_fmt)
      PT_MOVE, PT_CMOVE: c.op = OP_MOVE;
      PT_FMOVE, PT_CFMOVE: c.op = x[26] ? OP_REPLICATE : OP_EXTRACT;
      PT_DOUBLE, PT_LOCAL, PT_GLOBAL, PT_CGLOBAL: c.op = x[34] ? OP_LOAD : (x[33] ? OP_ADDR : OP_STORE);
      default: c.op = OP_NONE;
    endcase
    // moves carry no size or sign; only extracts name an item
    if (c.op == OP_MOVE) c.size = SZ_WORD;
    if (c.op inside {OP_MOVE, OP_REPLICATE}) c.sign = 1'b0;
    if (c.op != OP_EXTRACT) c.item = 2'h0;
    c.illegal = c.du_fmt == DU_RSVD || c.pt_fmt > 4'h9 || (c.op != OP_NONE && c.size == SZ_RSVD)
      || (c.op == OP_EXTRACT && (c.size == SZ_WORD || (c.size == SZ_HALF && c.item[1])));
    if (c.illegal)
    begin
      c.op = OP_NONE;
      return c;
    end
    c.glob = c.pt_fmt == PT_GLOBAL || c.pt_fmt == PT_CGLOBAL || (c.op == OP_MOVE && x[32]);
    c.mem_rd = c.op == OP_LOAD;
    c.mem_wr = c.op == OP_STORE;
    c.reg_we = !(c.op inside {OP_STORE, OP_NONE});
    f = (c.size == SZ_BYTE) ? {24'h0, s[8*c.item +: 8]} : {16'h0, s[16*c.item[0] +: 16]};
    case (c.op)
      OP_MOVE: md_exp = s;
      OP_EXTRACT: md_exp = !c.sign ? f : (c.size == SZ_BYTE) ? {{24{f[7]}}, f[7:0]} : {{16{f[15]}}, f[15:0]};
      OP_REPLICATE: md_exp = (c.size == SZ_WORD) ? s : (c.size == SZ_BYTE) ? {4{s[7:0]}} : {2{s[15:0]}};
      default: ;
    endcase
    return c;
  endfunction

  function automatic logic [63:0] gen(input logic [3:0] f);
    logic [63:0] x;
    x = {$random(seed), $random(seed)};
    x[63:58] = 6'h30;
    x[44] = 1'b0;
    x[38:35] = f;
    if (x[30:29] == 2'b11) x[30:29] = 2'b01;
    if (f inside {PT_FMOVE, PT_CFMOVE} && x[30:29] == 2'b00) x[29] = 1'b1;
    if (x[30]) x[28] = 1'b0;
    return x;
  endfunction

  task automatic check_ctrl(input ctrl_s c);
    check("valid", ctrl.valid, 1'b1);
    check("illegal", ctrl.illegal, c.illegal);
    check("du_fmt", ctrl.du_fmt, c.du_fmt);
    check("pt_fmt", ctrl.pt_fmt, c.pt_fmt);
    check("op", ctrl.op, c.op);
    check("strobes", {ctrl.mem_rd, ctrl.mem_wr, ctrl.reg_we}, {c.mem_rd, c.mem_wr, c.reg_we});
    check("glob", ctrl.glob, c.glob);
    if (c.op != OP_NONE) check("size_regs", {ctrl.size, ctrl.dst, ctrl.src, ctrl.areg}, {c.size, c.dst, c.src, c.areg});
    if (c.op inside {OP_LOAD, OP_EXTRACT, OP_MOVE}) check("sign", ctrl.sign, c.sign);
    if (c.op == OP_EXTRACT) check("item", ctrl.item, c.item);
    check("move_data", move_data, md_exp);
  endtask

  // back to back: check the previous opcode while the next one is driven
  task automatic run(input logic [63:0] ws [$]);
    ctrl_s pend;
    logic [31:0] s;
    for (int i = 0; i <= ws.size(); i++)
    begin
      @(posedge pclk);
      s = $random(seed);
      req_valid <= i < ws.size();
      req_word <= (i < ws.size()) ? ws[i] : '0;
      req_src <= s;
      #1;
      if (i > 0) check_ctrl(pend);
      if (i < ws.size()) pend = expect_of(ws[i], s);
      dec_cnt += i < ws.size();
      ill_cnt += i < ws.size() && pend.illegal;
    end
    @(posedge pclk);
    #1;
    check("valid_drop", ctrl.valid, 1'b0);
  endtask

  initial
  begin
    #40000;
    fails++;
    report_and_stop();
  end

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    #1;
    check("ctrl_rst", ctrl, '0);
    apb(0, CTRL_OFS, '0);
    check("ctrl_reg", rd, 32'h0000_0001);
    apb(0, COUNT_OFS, '0);
    check("count_rst", rd, 32'h0000_0000);
    apb(0, 12'h01C, '0);
    check("unmapped", {err, rd}, {1'b1, 32'h0});
    $display("reset and registers done");
    repeat (40) q.push_back(gen(4'($unsigned($random(seed)) % 10)));
    run(q);
    $display("random transfers done");
    q = {};
    for (int k = 0; k < 16; k++)
    begin
      w = gen(k inside {7, 8, 15} ? PT_FMOVE : PT_LOCAL);
      if (k < 6) w[38:35] = 4'(10 + k);
      case (k)
        6: w[30:29] = 2'b11;
        7: {w[30:29], w[26]} = 3'h0;
        8: {w[30:26]} = 5'b10100;
        9: w[63:61] = 3'h0;
        10: w[63:61] = 3'h2;
        11: w[63:61] = 3'h3;
        12: w[62:58] = MISC_PAT;
        13: w[44:43] = 2'b11;
        14: w[44:43] = 2'b10;
        15: {w[30:29], w[26]} = 3'b101;
        default: ;
      endcase
      q.push_back(w);
    end
    run(q);
    $display("corner opcodes done");
    w = gen(PT_FMOVE);
    {w[31], w[30:29], w[26]} = 4'b0011;
    apb(1, SRC_OFS, 32'hC3A5_7E19);
    apb(1, OPC_LO_OFS, w[31:0]);
    apb(1, OPC_HI_OFS, w[63:32]);
    e = expect_of(w, 32'hC3A5_7E19);
    dec_cnt++;
    n = 0;
    do
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    while (ctrl.valid !== 1'b1 && n < 10);
    check("issue_delay", n, 1);
    check_ctrl(e);
    apb(0, STATUS_OFS, '0);
    check("status", rd, {14'h0, e.glob, e.sign, e.item, e.size, e.op, e.pt_fmt, e.du_fmt, e.illegal, 1'b0});
    apb(0, RESULT_OFS, '0);
    check("result", rd, md_exp);
    apb(1, CTRL_OFS, '0);
    @(posedge pclk);
    req_valid <= 1;
    req_word <= gen(PT_MOVE);
    repeat (2)
    begin
      @(posedge pclk);
      req_valid <= 0;
      #1;
      check("disabled", ctrl.valid, 1'b0);
    end
    apb(1, CTRL_OFS, 32'h0000_0001);
    apb(0, COUNT_OFS, '0);
    check("count", rd, {16'(ill_cnt), 16'(dec_cnt)});
    $display("register issue done");
    report_and_stop();
  end
endmodule
